// ### logic/pcl_loader.sv
// Purpose: device side of the parallel configuration port (slave loading)
// Assumes: data, select and read/write pins are synchronous to i_config_clock
// Notes: link logic runs on i_config_clock, which may stop between bursts

`timescale 1ns/1ns
`default_nettype none

module pcl_loader (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_config_clock,
    input wire logic i_chip_select_n,
    input wire logic i_read_write_select,
    input wire logic [15:0] i_data,
    input wire logic [1:0] i_mode,
    output logic [15:0] o_data,
    output logic o_data_oe,
    output logic o_busy,
    output logic o_done,
    output logic o_init_ready,
    output logic [1:0] o_mode,
    output logic o_config_loaded
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bit reversal of one byte lane
    function automatic logic [7:0] pcl_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int k = 0; k < pcl_pkg::BYTE_W; k++) begin
            r[k] = v[pcl_pkg::BYTE_W - 1 - k];
        end
        return r;
    endfunction : pcl_rev8

    // ------------------------------------------------------------
    // main clock domain: init-ready, mode latch, loaded flag
    // ------------------------------------------------------------
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;
    logic [7:0] init_cnt;
    logic init_ready;
    logic [1:0] mode_latched;
    logic done_meta;
    logic done_sync;
    logic [7:0] next_init_cnt;
    logic next_init_ready;
    logic [1:0] next_mode_latched;

    // init-ready rises once the power-on clear time has run out
    always_comb begin
        next_init_cnt = init_cnt;
        next_init_ready = init_ready;
        next_mode_latched = mode_latched;
        if (!init_ready) begin
            if (init_cnt == pcl_pkg::INIT_CNT_W'(pcl_pkg::INIT_CYCLES - 1)) begin
                next_init_ready = 1'b1;
                next_mode_latched = mode_sync;
            end else begin
                next_init_cnt = init_cnt + 8'h01;
            end
        end
    end

    // mode pins are asynchronous straps, so two flops before use
    always_ff @(posedge i_mclk) begin
        mode_meta <= i_mode;
        mode_sync <= mode_meta;
        done_meta <= o_done;
        done_sync <= done_meta;
        if (i_rst) begin
            init_cnt <= 8'h00;
            init_ready <= 1'b0;
            mode_latched <= 2'h0;
        end else begin
            init_cnt <= next_init_cnt;
            init_ready <= next_init_ready;
            mode_latched <= next_mode_latched;
        end
    end

    assign o_init_ready = init_ready;
    assign o_mode = mode_latched;
    assign o_config_loaded = done_sync;

    // ------------------------------------------------------------
    // link domain: reset and init-ready crossings
    // ------------------------------------------------------------
    logic rst_meta;
    logic link_rst;
    logic init_meta;
    logic init_link;

    // reset only takes effect while the link clock runs; loading cannot
    // progress without edges anyway
    always_ff @(posedge i_config_clock) begin
        rst_meta <= i_rst;
        link_rst <= rst_meta;
        init_meta <= init_ready;
        init_link <= init_meta;
    end

    // ------------------------------------------------------------
    // link domain: sample decode
    // ------------------------------------------------------------
    pcl_pkg::pcl_state_type state;
    pcl_pkg::pcl_state_type next_state;
    logic x16;
    logic cand_x16;
    logic [31:0] shreg;
    logic [7:0] hold_byte;
    logic half;
    logic [2:0] done_phase;
    logic [2:0] phase;
    logic done_pin;
    logic abort_flag;
    logic sync_seen;
    logic [15:0] rd_data;
    logic next_x16;
    logic next_cand_x16;
    logic [31:0] next_shreg;
    logic [7:0] next_hold_byte;
    logic next_half;
    logic [2:0] next_done_phase;
    logic [2:0] next_phase;
    logic next_done_pin;
    logic next_abort_flag;
    logic next_sync_seen;
    logic [15:0] next_rd_data;

    logic accept;
    logic violation;
    logic [7:0] byte8;
    logic [15:0] word16;
    logic word_vld;
    logic [15:0] word;

    // edges with select high carry nothing
    assign accept = ~i_chip_select_n & ~i_read_write_select;
    assign violation = ~i_chip_select_n & i_read_write_select;
    assign byte8 = pcl_rev8(i_data[7:0]);
    assign word16 = {pcl_rev8(i_data[15:8]), pcl_rev8(i_data[7:0])};

    // x8 pairs two bytes into a word, first byte high
    always_comb begin
        word_vld = 1'b0;
        word = word16;
        if (accept) begin
            if (x16) begin
                word_vld = 1'b1;
            end else begin
                word_vld = half;
                word = {hold_byte, byte8};
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: loading state machine
    // ------------------------------------------------------------
    // all state sits in flops clocked by the link clock only, so a
    // stopped clock freezes detection progress as it is
    always_comb begin
        next_state = state;
        next_x16 = x16;
        next_cand_x16 = cand_x16;
        next_shreg = shreg;
        next_hold_byte = hold_byte;
        next_half = half;
        next_done_phase = done_phase;
        next_phase = phase;
        next_done_pin = done_pin;
        next_abort_flag = abort_flag;
        next_sync_seen = sync_seen;
        if (accept && !x16 && (state == pcl_pkg::S_LOAD || state == pcl_pkg::S_ARG)) begin
            next_half = ~half;
            next_hold_byte = byte8;
        end
        unique case (state)
            pcl_pkg::S_WAIT_INIT: begin
                if (init_link) begin
                    next_state = pcl_pkg::S_WIDTH;
                end
            end
            pcl_pkg::S_WIDTH: begin
                if (accept) begin
                    if (word16 == pcl_pkg::WIDTH_X16_FIRST) begin
                        next_cand_x16 = 1'b1;
                        next_state = pcl_pkg::S_WIDTH2;
                    end else if (byte8 == pcl_pkg::WIDTH_X8_FIRST) begin
                        next_cand_x16 = 1'b0;
                        next_state = pcl_pkg::S_WIDTH2;
                    end
                end
            end
            pcl_pkg::S_WIDTH2: begin
                if (accept) begin
                    if (cand_x16 ? (word16 == pcl_pkg::WIDTH_X16_SECOND)
                                 : (byte8 == pcl_pkg::WIDTH_X8_SECOND)) begin
                        next_x16 = cand_x16;
                        next_shreg = '0;
                        next_state = pcl_pkg::S_SYNC;
                    end else begin
                        next_state = pcl_pkg::S_WIDTH;
                    end
                end
            end
            pcl_pkg::S_SYNC: begin
                if (accept) begin
                    next_shreg = x16 ? {shreg[15:0], word16} : {shreg[23:0], byte8};
                    if (next_shreg == pcl_pkg::SYNC_WORD) begin
                        next_sync_seen = 1'b1;
                        next_half = 1'b0;
                        next_state = pcl_pkg::S_LOAD;
                    end
                end
            end
            pcl_pkg::S_LOAD: begin
                if (word_vld && word == pcl_pkg::START_CMD) begin
                    next_state = pcl_pkg::S_ARG;
                end
            end
            pcl_pkg::S_ARG: begin
                if (word_vld) begin
                    next_done_phase = word[pcl_pkg::DONE_PHASE_LSB +: pcl_pkg::PHASE_W];
                    next_phase = 3'h0;
                    next_state = pcl_pkg::S_STARTUP;
                end
            end
            pcl_pkg::S_STARTUP: begin
                // one phase per link edge, select no longer matters
                if (phase == done_phase) begin
                    next_done_pin = 1'b1;
                end
                if (phase == pcl_pkg::STARTUP_LAST_PHASE) begin
                    next_state = pcl_pkg::S_DONE;
                end else begin
                    next_phase = phase + 3'h1;
                end
            end
            pcl_pkg::S_DONE: begin
                next_done_pin = 1'b1;
            end
            pcl_pkg::S_ABORT: begin
                next_state = pcl_pkg::S_ABORT;
            end
            // unused codes only show before the link reset lands
            default: begin
                next_state = pcl_pkg::S_WAIT_INIT;
            end
        endcase
        // abort only while loading; status is written on this edge
        if (violation && (state == pcl_pkg::S_WIDTH || state == pcl_pkg::S_WIDTH2 ||
                state == pcl_pkg::S_SYNC || state == pcl_pkg::S_LOAD ||
                state == pcl_pkg::S_ARG)) begin
            next_abort_flag = 1'b1;
            next_state = pcl_pkg::S_ABORT;
        end
        next_rd_data = '0;
        next_rd_data[pcl_pkg::STAT_ABORT_BIT] = next_abort_flag;
        next_rd_data[pcl_pkg::STAT_SYNC_BIT] = next_sync_seen;
        next_rd_data[pcl_pkg::STAT_DONE_BIT] = next_done_pin;
        next_rd_data[pcl_pkg::STAT_X16_BIT] = next_x16;
    end

    // registers of the loading machine
    always_ff @(posedge i_config_clock) begin
        if (link_rst) begin
            state <= pcl_pkg::S_WAIT_INIT;
            x16 <= 1'b0;
            cand_x16 <= 1'b0;
            shreg <= '0;
            hold_byte <= 8'h00;
            half <= 1'b0;
            done_phase <= 3'h0;
            phase <= 3'h0;
            done_pin <= 1'b0;
            abort_flag <= 1'b0;
            sync_seen <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            state <= next_state;
            x16 <= next_x16;
            cand_x16 <= next_cand_x16;
            shreg <= next_shreg;
            hold_byte <= next_hold_byte;
            half <= next_half;
            done_phase <= next_done_phase;
            phase <= next_phase;
            done_pin <= next_done_pin;
            abort_flag <= next_abort_flag;
            sync_seen <= next_sync_seen;
            rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // busy follows the pins without a clock so the controller sees a
    // wrong read/write level at once; the status flop catches up later
    assign o_busy = ~i_chip_select_n & (state != pcl_pkg::S_DONE) &
                    (i_read_write_select | abort_flag);
    assign o_data_oe = ~i_chip_select_n & i_read_write_select;
    assign o_data = rd_data;
    assign o_done = done_pin;

endmodule : pcl_loader

`default_nettype wire

// ### logic/pcl_pkg.sv
// Purpose: shared constants and types for the parallel configuration data loader
// Assumes: 16-bit data pins, 8-phase startup, system clock at 125 MHz
// Notes: detection patterns and command codes are plain defaults

`default_nettype none

package pcl_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SHIFT_W = 32;
    localparam int MODE_W = 2;
    localparam int PHASE_W = 3;

    // ------------------------------------------------------------
    // stream patterns (after pin reordering)
    // ------------------------------------------------------------
    localparam logic [BYTE_W-1:0] WIDTH_X8_FIRST = 8'hbb;
    localparam logic [BYTE_W-1:0] WIDTH_X8_SECOND = 8'h11;
    localparam logic [DATA_W-1:0] WIDTH_X16_FIRST = 16'h00bb;
    localparam logic [DATA_W-1:0] WIDTH_X16_SECOND = 16'h1122;
    localparam logic [SHIFT_W-1:0] SYNC_WORD = 32'haa995566;
    // startup command header; the word after it carries the done phase
    localparam logic [DATA_W-1:0] START_CMD = 16'h30a1;
    localparam int DONE_PHASE_LSB = 0;

    // ------------------------------------------------------------
    // startup and init timing
    // ------------------------------------------------------------
    localparam logic [PHASE_W-1:0] STARTUP_LAST_PHASE = 3'h7; // eight link cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W = 8;

    // ------------------------------------------------------------
    // readback status word bit positions
    // ------------------------------------------------------------
    localparam int STAT_ABORT_BIT = 0;
    localparam int STAT_SYNC_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_X16_BIT = 3;

    // loading states on the link clock
    typedef enum logic [3:0] {
        S_WAIT_INIT,
        S_WIDTH,
        S_WIDTH2,
        S_SYNC,
        S_LOAD,
        S_ARG,
        S_STARTUP,
        S_DONE,
        S_ABORT
    } pcl_state_type;

endpackage : pcl_pkg

`default_nettype wire

// ### logic/pcl_loader_unused_guard.sv
// Purpose: holds no logic; the whole loader sits in pcl_loader.sv
// Assumes: nothing
// Notes: kept empty on purpose so no second copy of the loader appears
`timescale 1ns/1ns

// ### bench/pcl_loader_monitor.sv
// Purpose: port checks for the parallel config loader
// Assumes: link inputs change away from link rising edges
// Notes: busy and oe are pin-combinational, so mclk samples them
`timescale 1ns/1ns
`default_nettype none
module pcl_loader_monitor (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_config_clock,
    input wire logic i_chip_select_n,
    input wire logic i_read_write_select,
    input wire logic [1:0] i_mode,
    input wire logic [15:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_init_ready,
    input wire logic [1:0] o_mode,
    input wire logic o_config_loaded
);
    // ----------------------------------------
    // pin and system-clock checks
    // ----------------------------------------
    a_oe_pins: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_data_oe == (!i_chip_select_n && i_read_write_select)) else $error("pin enable wrong");
    a_busy_write: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!i_chip_select_n && !i_read_write_select) |-> !o_busy) else $error("busy high on write");
    a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_chip_select_n |-> !o_data_oe && !o_busy) else $error("active while deselected");
    a_mode_latch: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(o_init_ready) |-> o_mode == $past(i_mode, 3)) else $error("mode not latched");
    a_init_stays: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_init_ready |=> o_init_ready && $stable(o_mode)) else $error("init ready dropped");
    a_loaded_follows: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(o_done) |-> ##[1:4] o_config_loaded) else $error("loaded flag late");
    // ----------------------------------------
    // link-clock checks
    // ----------------------------------------
    a_done_sticky: assert property (@(posedge i_config_clock) disable iff (i_rst)
        o_done |=> o_done) else $error("done dropped");
    a_abort_sticky: assert property (@(posedge i_config_clock) disable iff (i_rst)
        o_data[0] |=> o_data[0] && !$rose(o_done)) else $error("abort not sticky");
    a_no_late_abort: assert property (@(posedge i_config_clock) disable iff (i_rst)
        o_done |=> !$rose(o_data[0])) else $error("abort after done");
    a_sync_first: assert property (@(posedge i_config_clock) disable iff (i_rst)
        $rose(o_done) |-> o_data[1]) else $error("done without sync");
    c_done: cover property (@(posedge i_config_clock) $rose(o_done));
    c_abort: cover property (@(posedge i_config_clock) $rose(o_data[0]));
    c_wide: cover property (@(posedge i_config_clock) o_done && o_data[3]);
endmodule : pcl_loader_monitor
bind pcl_loader pcl_loader_monitor mon (.i_mclk, .i_rst, .i_config_clock, .i_chip_select_n,
    .i_read_write_select, .i_mode, .o_data, .o_data_oe, .o_busy, .o_done, .o_init_ready,
    .o_mode, .o_config_loaded);
`default_nettype wire

// ### bench/pcl_ctrl_model.sv
// Purpose: configuration controller driving the loader's link pins
// Assumes: 160 ns link period, clock only runs inside cycles
// Notes: a deselected bus inverts the pins each cycle, so the last word returns every second deselected cycle
`timescale 1ns/1ns
`default_nettype none
module pcl_ctrl_model (
    output logic o_clk,
    output logic o_cs_n,
    output logic o_rw,
    output logic [15:0] o_pins
);
    // idle controller: clock still, deselected, write direction
    initial begin
        o_clk = 1'b0;
        o_cs_n = 1'b1;
        o_rw = 1'b0;
        o_pins = 16'h0;
    end
    // one link cycle; select rises before direction moves when deselecting; when selecting, direction moves first
    task automatic cyc(input logic [15:0] pins, input logic cs_n, input logic rw);
        if (cs_n) o_cs_n = 1'b1;
        o_rw = rw;
        #1;
        o_cs_n = cs_n;
        o_pins = cs_n ? ~o_pins : pins;
        #79 o_clk = 1'b1;
        #80 o_clk = 1'b0;
    endtask : cyc
    // direction change under select, used only to provoke an abort
    task automatic flip(input logic rw);
        o_rw = rw;
        #2;
    endtask : flip
endmodule : pcl_ctrl_model
`default_nettype wire

// ### bench/pcl_loader_bench.sv
// Purpose: self-checking bench for the parallel config loader
// Assumes: controller model owns the link pins
// Notes: reset is held across link edges so the link side clears too
`timescale 1ns/1ns
`default_nettype none
module pcl_loader_bench;
    typedef struct {logic x16; logic [2:0] ph; logic [1:0] pause; logic [1:0] mode;
        logic [15:0] stat;} pcl_row_type;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] i_mode = 2'h0;
    logic config_clock, cs_n, rw, o_data_oe, o_busy, o_done, o_init_ready, o_config_loaded;
    logic [15:0] pins, o_data;
    logic [1:0] o_mode;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    // pause: 0 none, 1 deselect, 2 stopped clock; stat is sync, done and width bits
    pcl_row_type rows [4] = '{'{1'b0, 3'h0, 2'h0, 2'h1, 16'h0006},
        '{1'b1, 3'h7, 2'h1, 2'h2, 16'h000e}, '{1'b0, 3'h3, 2'h2, 2'h3, 16'h0006},
        '{1'b1, 3'h5, 2'h0, 2'h0, 16'h000e}};
    pcl_ctrl_model ctl (.o_clk(config_clock), .o_cs_n(cs_n), .o_rw(rw), .o_pins(pins));
    pcl_loader dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_config_clock(config_clock),
        .i_chip_select_n(cs_n), .i_read_write_select(rw), .i_data(pins), .i_mode(i_mode),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_busy(o_busy), .o_done(o_done),
        .o_init_ready(o_init_ready), .o_mode(o_mode), .o_config_loaded(o_config_loaded));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #4 i_mclk = ~i_mclk;
    // hang guard: whole run needs well under 20000 cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction : rev8
    // one stream word: one x16 cycle or two x8 cycles, high byte first
    task automatic wr(input logic [15:0] w, input logic x16);
        if (x16) begin
            ctl.cyc({rev8(w[15:8]), rev8(w[7:0])}, 1'b0, 1'b0);
        end else begin
            ctl.cyc({8'hff, rev8(w[15:8])}, 1'b0, 1'b0);
            ctl.cyc({8'hff, rev8(w[7:0])}, 1'b0, 1'b0);
        end
    endtask : wr
    task automatic do_reset(input logic [1:0] mode);
        int w;
        @(posedge i_mclk);
        i_mode <= mode;
        i_rst <= 1'b1;
        repeat (6) @(posedge i_mclk);
        repeat (4) ctl.cyc(16'h0, 1'b1, 1'b0);
        @(posedge i_mclk);
        i_rst <= 1'b0;
        w = 0;
        while (o_init_ready !== 1'b1 && w < 300) begin
            @(posedge i_mclk);
            w++;
        end
        repeat (3) ctl.cyc(16'h0, 1'b1, 1'b0);
        chk({14'h0, o_mode}, {14'h0, mode});
        chk(16'(o_init_ready), 16'h1);
        chk(o_data, 16'h0);
        chk(16'(o_done), 16'h0);
    endtask : do_reset
    // width pattern then sync word; upper pins carry noise in x8
    task automatic head(input logic x16);
        if (x16) begin
            wr(pcl_pkg::WIDTH_X16_FIRST, 1'b1);
            wr(pcl_pkg::WIDTH_X16_SECOND, 1'b1);
        end else begin
            wr({pcl_pkg::WIDTH_X8_FIRST, pcl_pkg::WIDTH_X8_SECOND}, 1'b0);
        end
        chk(16'(o_busy), 16'h0);
        wr(pcl_pkg::SYNC_WORD[31:16], x16);
        wr(pcl_pkg::SYNC_WORD[15:0], x16);
    endtask : head
    task automatic run_row(input pcl_row_type r);
        do_reset(r.mode);
        head(r.x16);
        wr(16'h0, r.x16);
        wr(pcl_pkg::START_CMD, r.x16);
        if (r.pause == 2'h1) begin
            ctl.cyc(16'h0, 1'b1, 1'b1);
            chk({o_data_oe, o_busy, o_data[0]}, 16'h0);
            ctl.cyc(16'h0, 1'b1, 1'b0);
        end
        if (r.pause == 2'h2) #3000;
        wr({13'h0, r.ph}, r.x16);
        for (int k = 0; k < 10; k++) begin
            ctl.cyc(16'h0, 1'b1, 1'b0);
            chk(16'(o_done), 16'(k >= int'(r.ph)));
        end
        chk(o_data, r.stat);
        repeat (6) @(posedge i_mclk);
        chk(16'(o_config_loaded), 16'h1);
    endtask : run_row
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        foreach (rows[i]) run_row(rows[i]);
        // direction toggles under select after done are harmless
        ctl.cyc(16'h0, 1'b0, 1'b0);
        ctl.cyc(16'h0, 1'b0, 1'b1);
        chk(16'(o_data_oe), 16'h1);
        chk(o_data, rows[3].stat);
        // direction flip in mid-load: busy at once, status one edge later
        do_reset(2'h0);
        head(1'b0);
        ctl.flip(1'b1);
        chk({o_busy, o_data[0]}, 16'h2);
        ctl.cyc(16'h0, 1'b0, 1'b1);
        chk(16'(o_data[0]), 16'h1);
        repeat (12) ctl.cyc(16'h0, 1'b1, 1'b0);
        chk(16'(o_done), 16'h0);
        end_of_test();
    end
endmodule : pcl_loader_bench
`default_nettype wire
